// file: core/ja_pkg.sv
// Shared constants for the jitter attenuator channel control block.
// Assumes an 8-bit parallel register port and twelve channels.
package ja_pkg;
  localparam int NUM_CHANNELS = 12;
  localparam int CTRL_WIDTH = 4;
  localparam int FIFO_DEPTH_SHALLOW = 16;
  localparam int FIFO_DEPTH_DEEP = 32;
  localparam logic [3:0] CTRL_LOW_NIBBLE = 4'h7;
  localparam logic [3:0] LOWER_BANK_END_ROW = 4'h6;
  localparam logic [3:0] UPPER_BANK_FIRST_ROW = 4'h8;
  localparam logic [3:0] UPPER_BANK_LAST_ROW = 4'hD;
  localparam logic [3:0] UPPER_BANK_ROW_SHIFT = 4'h2;
  localparam int CFG_ZERO_BIT = 0;
  localparam int PATH_SELECT_BIT = 1;
  localparam int CFG_ONE_BIT = 2;
  localparam int FLUSH_RESET_BIT = 3;
  localparam logic [3:0] CTRL_RESET_VALUE = 4'h0;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
endpackage

// file: core/ja_fifo_if.sv
// Carrier between channel control and one attenuator FIFO.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface ja_fifo_if;
  logic flush;
  logic deep;
  logic wr_en;
  logic wr_bit;
  logic rd_en;
  logic rd_bit;
  logic rd_valid;
  logic [5:0] level;
  modport fifo (
    input flush, deep, wr_en, wr_bit, rd_en,
    output rd_bit, rd_valid, level
  );
  modport ctl (
    output flush, deep, wr_en, wr_bit, rd_en,
    input rd_bit, rd_valid, level
  );
endinterface

// file: core/ja_fifo.sv
// One-bit wide attenuator FIFO with selectable depth.
// Assumes write and read strobes are one-cycle enables on mclk_i.
`timescale 1ns/1ns
module ja_fifo #(
  parameter int DEPTH_MAX = ja_pkg::FIFO_DEPTH_DEEP,
  parameter int DEPTH_MIN = ja_pkg::FIFO_DEPTH_SHALLOW
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  ja_fifo_if.fifo port
);
  localparam int PW = $clog2(DEPTH_MAX);
  logic [DEPTH_MAX-1:0] mem_reg, mem_next;
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [PW:0] count_reg, count_next;
  logic rd_bit_reg, rd_bit_next, rd_valid_reg, rd_valid_next;
  logic [PW:0] limit;
  logic do_wr, do_rd;

  assign port.rd_bit = rd_bit_reg;
  assign port.rd_valid = rd_valid_reg;
  assign port.level = 6'(count_reg);

  always_comb begin
    limit = port.deep ? (PW+1)'(DEPTH_MAX) : (PW+1)'(DEPTH_MIN);
    do_wr = port.wr_en && (count_reg < limit);
    do_rd = port.rd_en && (count_reg != '0);
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    rd_bit_next = rd_bit_reg;
    rd_valid_next = 1'b0;
    if (port.flush) begin
      // Pointers home and contents dropped
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
      mem_next = '0;
    end else begin
      if (do_wr) begin
        mem_next[wr_ptr_reg] = port.wr_bit;
        wr_ptr_next = ({1'b0, wr_ptr_reg} == limit - 1'b1) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_bit_next = mem_reg[rd_ptr_reg];
        rd_valid_next = 1'b1;
        rd_ptr_next = ({1'b0, rd_ptr_reg} == limit - 1'b1) ? '0 : rd_ptr_reg + 1'b1;
      end
      // Overflow drops the incoming bit rather than corrupt order
      count_next = count_reg + (PW+1)'(do_wr) - (PW+1)'(do_rd);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_reg <= '0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      rd_bit_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      rd_bit_reg <= rd_bit_next;
      rd_valid_reg <= rd_valid_next;
    end
  end
endmodule

// file: core/jitter_attenuator_channel_control.sv
// Per-channel attenuator control registers and data steering, twelve channels.
// Assumes line bits arrive as one-cycle valid strobes on mclk_i and that the
// smoothed read strobe comes from the clock-smoothing loop outside.
`timescale 1ns/1ns
module jitter_attenuator_channel_control #(
  parameter int NCH = ja_pkg::NUM_CHANNELS,
  parameter int DEPTH_MAX = ja_pkg::FIFO_DEPTH_DEEP,
  parameter int DEPTH_MIN = ja_pkg::FIFO_DEPTH_SHALLOW
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [NCH-1:0] rx_bit_i,
  input wire logic [NCH-1:0] rx_valid_i,
  input wire logic [NCH-1:0] tx_bit_i,
  input wire logic [NCH-1:0] tx_valid_i,
  input wire logic [NCH-1:0] smooth_rd_en_i,
  output logic [NCH-1:0] rx_bit_o,
  output logic [NCH-1:0] rx_valid_o,
  output logic [NCH-1:0] tx_bit_o,
  output logic [NCH-1:0] tx_valid_o
);
  logic [3:0] row;
  logic [3:0] sel_ch;
  logic mapped;
  logic [7:0] rdata_reg, rdata_next;
  logic [3:0] ctrl_reg [NCH];
  logic [NCH-1:0] flush_w;
  logic [5:0] level_w [NCH];
  logic [NCH-1:0] fifo_valid_w;

  // Rows 0-5 hold channels 0-5, rows 8-D hold channels 6-11
  always_comb begin
    row = addr_i[7:4];
    mapped = (addr_i[3:0] == ja_pkg::CTRL_LOW_NIBBLE) &&
             ((row < ja_pkg::LOWER_BANK_END_ROW) ||
              ((row >= ja_pkg::UPPER_BANK_FIRST_ROW) && (row <= ja_pkg::UPPER_BANK_LAST_ROW)));
    sel_ch = (row < ja_pkg::LOWER_BANK_END_ROW) ? row : row - ja_pkg::UPPER_BANK_ROW_SHIFT;
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (rd_i) begin
      // Reserved bits read as zero, unmapped reads idle value
      rdata_next = mapped ? {4'h0, ctrl_reg[sel_ch]} : ja_pkg::READ_IDLE_VALUE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= ja_pkg::READ_IDLE_VALUE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_o = rdata_reg;

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : gen_ch
      logic [3:0] c_reg, c_next;
      logic deep_prev_reg, deep_prev_next;
      logic rxb_reg, rxb_next, rxv_reg, rxv_next;
      logic txb_reg, txb_next, txv_reg, txv_next;
      logic en, on_tx;
      ja_fifo_if ch_if ();

      ja_fifo #(
        .DEPTH_MAX(DEPTH_MAX),
        .DEPTH_MIN(DEPTH_MIN)
      ) u_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .port(ch_if)
      );

      assign en = !c_reg[ja_pkg::CFG_ZERO_BIT];
      assign on_tx = c_reg[ja_pkg::PATH_SELECT_BIT];
      // Level-held: covers the rising write and the whole time the bit stays set.
      // A depth change also flushes, since old pointers would not fit the new wrap.
      assign ch_if.flush = c_reg[ja_pkg::FLUSH_RESET_BIT] || !en ||
                           (deep_prev_reg != c_reg[ja_pkg::CFG_ONE_BIT]);
      assign ch_if.deep = c_reg[ja_pkg::CFG_ONE_BIT];
      assign ch_if.wr_en = en && (on_tx ? tx_valid_i[i] : rx_valid_i[i]);
      assign ch_if.wr_bit = on_tx ? tx_bit_i[i] : rx_bit_i[i];
      assign ch_if.rd_en = en && smooth_rd_en_i[i];
      assign flush_w[i] = ch_if.flush;
      assign level_w[i] = ch_if.level;
      assign fifo_valid_w[i] = ch_if.rd_valid;
      assign ctrl_reg[i] = c_reg;

      always_comb begin
        c_next = c_reg;
        if (wr_i && mapped && (sel_ch == 4'(i))) begin
          c_next = wdata_i[3:0];
        end
        deep_prev_next = c_reg[ja_pkg::CFG_ONE_BIT];
        rxb_next = rx_bit_i[i];
        rxv_next = rx_valid_i[i];
        txb_next = tx_bit_i[i];
        txv_next = tx_valid_i[i];
        if (en && !on_tx) begin
          rxb_next = ch_if.rd_bit;
          rxv_next = ch_if.rd_valid;
        end
        if (en && on_tx) begin
          txb_next = ch_if.rd_bit;
          txv_next = ch_if.rd_valid;
        end
      end

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          c_reg <= ja_pkg::CTRL_RESET_VALUE;
          deep_prev_reg <= 1'b0;
          rxb_reg <= 1'b0;
          rxv_reg <= 1'b0;
          txb_reg <= 1'b0;
          txv_reg <= 1'b0;
        end else begin
          c_reg <= c_next;
          deep_prev_reg <= deep_prev_next;
          rxb_reg <= rxb_next;
          rxv_reg <= rxv_next;
          txb_reg <= txb_next;
          txv_reg <= txv_next;
        end
      end
      assign rx_bit_o[i] = rxb_reg;
      assign rx_valid_o[i] = rxv_reg;
      assign tx_bit_o[i] = txb_reg;
      assign tx_valid_o[i] = txv_reg;
    end
  endgenerate

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  AST_MAP_WRITE: assert property (
    wr_i && addr_i == 8'h97 |=> ctrl_reg[7] == $past(wdata_i[3:0]))
    else $error("write to 0x97 did not reach channel 7");
  AST_MAP_READ: assert property (
    rd_i && addr_i == 8'hD7 |=> rdata_o == {4'h0, $past(ctrl_reg[11])})
    else $error("read of 0xD7 did not return channel 11");
  AST_RISE_FLUSH: assert property (
    $rose(ctrl_reg[0][3]) |-> flush_w[0])
    else $error("rising reset bit did not flush channel 0");
  AST_PTR_HOME: assert property (
    flush_w[0] |=> level_w[0] == 6'h00)
    else $error("flush left fifo occupancy nonzero");
  AST_DISCARD: assert property (
    flush_w[0] && ctrl_reg[0][1:0] == 2'h0 ##1 flush_w[0] && ctrl_reg[0][1:0] == 2'h0
    |=> !fifo_valid_w[0] && !rx_valid_o[0])
    else $error("flushed fifo still produced data");
  AST_HOLD: assert property (
    ctrl_reg[0][3] [*3] |-> level_w[0] == 6'h00 && flush_w[0])
    else $error("attenuator left reset while bit held");
  AST_DEPTH16: assert property (
    !ctrl_reg[0][0] && !ctrl_reg[0][2] && $past(!ctrl_reg[0][2]) |-> level_w[0] <= 6'h10)
    else $error("shallow fifo exceeded 16");
  AST_DEPTH32: assert property (
    ctrl_reg[0][2] && !ctrl_reg[0][0] |-> level_w[0] <= 6'h20)
    else $error("deep fifo exceeded 32");
  AST_PATH_TX: assert property (
    ctrl_reg[0][1:0] == 2'h2 |=> rx_bit_o[0] == $past(rx_bit_i[0]) &&
    rx_valid_o[0] == $past(rx_valid_i[0]))
    else $error("receive path not bypassed with attenuator on transmit");
  AST_BYPASS: assert property (
    ctrl_reg[0][0] |=> tx_bit_o[0] == $past(tx_bit_i[0]) && rx_bit_o[0] == $past(rx_bit_i[0]))
    else $error("disabled attenuator did not bypass");

  // Data checks watch channel 0; the bench runs its first pass there
  AST_MAP_LOW: assert property (
    wr_i && addr_i == 8'h27 |=> ctrl_reg[2] == $past(wdata_i[3:0]))
    else $error("write to 0x27 did not reach channel 2");
  AST_GAP_WRITE: assert property (
    wr_i && addr_i == 8'h67 |=> ctrl_reg[4] == $past(ctrl_reg[4]))
    else $error("write to an unmapped row changed channel 4");
  AST_GAP_READ: assert property (
    rd_i && !mapped |=> rdata_o == ja_pkg::READ_IDLE_VALUE)
    else $error("unmapped read did not return the idle value");
  AST_RESERVED: assert property (
    rdata_o[7:4] == 4'h0)
    else $error("reserved read bits not zero");

  AST_PTR_ZERO: assert property (
    flush_w[0] |=> gen_ch[0].u_fifo.wr_ptr_reg == '0 && gen_ch[0].u_fifo.rd_ptr_reg == '0)
    else $error("flush left a fifo pointer away from home");
  AST_FLUSH_NO_READ: assert property (
    flush_w[0] |=> !fifo_valid_w[0])
    else $error("fifo produced a bit in the cycle after a flush");
  // Old pointers would not fit a new wrap, so a depth change must empty the fifo
  AST_DEPTH_SWITCH: assert property (
    ctrl_reg[0][2] != $past(ctrl_reg[0][2]) |=> level_w[0] == 6'h00)
    else $error("depth change kept stale fifo contents");

  AST_RX_SOURCE: assert property (
    ctrl_reg[0][1:0] == 2'h0 |=> rx_valid_o[0] == $past(fifo_valid_w[0]))
    else $error("receive output not taken from the fifo");
  AST_TX_SOURCE: assert property (
    ctrl_reg[0][1:0] == 2'h2 |=> tx_valid_o[0] == $past(fifo_valid_w[0]))
    else $error("transmit output not taken from the fifo");
  AST_BYPASS_VALID: assert property (
    ctrl_reg[0][0] |=> rx_valid_o[0] == $past(rx_valid_i[0]) &&
    tx_valid_o[0] == $past(tx_valid_i[0]))
    else $error("disabled attenuator did not pass valid strobes");

  // Scenario covers
  COV_DEEP_FILL: cover property (ctrl_reg[0][2] && level_w[0] == 6'h11);
  COV_SHALLOW_FULL: cover property (!ctrl_reg[0][2] && level_w[0] == 6'h10);
  COV_TX_OUT: cover property (ctrl_reg[0][1:0] == 2'h2 && tx_valid_o[0]);
  COV_RESET_CYCLE: cover property ($rose(ctrl_reg[0][3]) ##[1:50] $fell(ctrl_reg[0][3]));
  COV_BYPASS_RX: cover property (ctrl_reg[0][0] && rx_valid_o[0]);
endmodule

// file: verification/ja_host_model.sv
// Host model: register writes and reads on the parallel port.
// Assumes strobes are sampled on rising mclk_i.
`timescale 1ns/1ns
module ja_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Released lines show the inverse, not the stale value
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule

// file: verification/jitter_attenuator_channel_control_bench.sv
// Bench for the channel control block: registers, bypass, depth, flush.
// Assumes ja_host_model drives the register port.
`timescale 1ns/1ns
module jitter_attenuator_channel_control_bench;
  logic mclk_i, rst_n_i, wr, rd;
  logic [7:0] addr, wdata, rdata, v;
  logic [11:0] rx_bit_i, rx_valid_i, tx_bit_i, tx_valid_i, smooth_rd_en_i, last;
  logic [11:0] rx_bit_o, rx_valid_o, tx_bit_o, tx_valid_o;
  int bad_count, comparisons, cycles, rx_seen, tx_seen, seed, c, b, depth;
  jitter_attenuator_channel_control i_jitter_attenuator_channel_control (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .rx_bit_i(rx_bit_i), .rx_valid_i(rx_valid_i),
    .tx_bit_i(tx_bit_i), .tx_valid_i(tx_valid_i), .smooth_rd_en_i(smooth_rd_en_i),
    .rx_bit_o(rx_bit_o), .rx_valid_o(rx_valid_o), .tx_bit_o(tx_bit_o),
    .tx_valid_o(tx_valid_o));
  ja_host_model i_ja_host_model (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  function automatic logic [7:0] reg_addr(int ch);
    return (ch < 6) ? 8'(ch * 16 + 7) : 8'(ch * 16 + 39);
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    #1;
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cfg(logic [7:0] d);
    i_ja_host_model.write_reg(reg_addr(c), d);
    repeat (3) @(posedge mclk_i);
    #1;
    rx_seen = 0;
    tx_seen = 0;
  endtask
  task automatic stream(bit tx, int n);
    repeat (n) begin
      @(posedge mclk_i);
      last = 12'($random(seed));
      rx_bit_i <= last;
      tx_bit_i <= ~last;
      rx_valid_i <= tx ? 12'h000 : 12'h001 << c;
      tx_valid_i <= tx ? 12'h001 << c : 12'h000;
    end
    @(posedge mclk_i);
    rx_valid_i <= 12'h000;
    tx_valid_i <= 12'h000;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic drain(int n);
    @(posedge mclk_i);
    smooth_rd_en_i <= 12'hFFF;
    repeat (n) @(posedge mclk_i);
    smooth_rd_en_i <= 12'h000;
    repeat (4) @(posedge mclk_i);
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // Ceiling at 8000 cycles, well above the roughly 650 cycles the tests take
  always @(posedge mclk_i) begin
    cycles++;
    rx_seen += $countones(rx_valid_o);
    tx_seen += $countones(tx_valid_o);
    if (cycles == 8000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    seed = 45;
    rst_n_i = 1'b0;
    {rx_bit_i, rx_valid_i, tx_bit_i, tx_valid_i, smooth_rd_en_i} = '0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int ch = 0; ch < 12; ch++) begin
      i_ja_host_model.read_reg(reg_addr(ch), v);
      check("reset value", v, {4'h0, ja_pkg::CTRL_RESET_VALUE});
      b = $random(seed);
      i_ja_host_model.write_reg(reg_addr(ch), 8'(b));
      i_ja_host_model.read_reg(reg_addr(ch), v);
      check("readback", v, {4'h0, 4'(b)});
      i_ja_host_model.write_reg(reg_addr(ch), 8'h00);
    end
    i_ja_host_model.read_reg(8'h66, v);
    check("unmapped read", v, ja_pkg::READ_IDLE_VALUE);
    // Row 6 lies between the banks; a write there must not alias channel 4
    i_ja_host_model.write_reg(8'h67, 8'h0F);
    i_ja_host_model.read_reg(8'h67, v);
    check("gap read", v, ja_pkg::READ_IDLE_VALUE);
    i_ja_host_model.read_reg(reg_addr(4), v);
    check("gap write", v, 8'h00);
    // Channel 0 first, where the embedded checks look, then a random one
    for (int pass = 0; pass < 2; pass++) begin
      c = pass ? $unsigned($random(seed)) % 12 : 0;
      cfg(8'h01);
      stream(0, 1);
      check("rx bypass count", 8'(rx_seen), 8'h01);
      check("rx bypass bit", {7'h0, rx_bit_o[c]}, {7'h0, last[c]});
      cfg(8'h03);
      stream(1, 1);
      check("tx bypass bit", {7'h0, tx_bit_o[c]}, {7'h0, ~last[c]});
      check("tx bypass count", 8'(tx_seen), 8'h01);
      cfg(8'h02);
      stream(1, 5);
      check("tx held in fifo", 8'(tx_seen), 8'h00);
      stream(0, 2);
      check("rx passes", 8'(rx_seen), 8'h02);
      drain(8);
      check("tx drained", 8'(tx_seen), 8'h05);
      // Overfill by a few, then drain more than the depth
      for (int d = 0; d < 2; d++) begin
        depth = d ? ja_pkg::FIFO_DEPTH_DEEP : ja_pkg::FIFO_DEPTH_SHALLOW;
        cfg(d ? 8'h04 : 8'h00);
        stream(0, depth + 4);
        drain(depth + 8);
        check("fifo depth", 8'(rx_seen), 8'(depth));
      end
      cfg(8'h00);
      stream(0, 6);
      i_ja_host_model.write_reg(reg_addr(c), 8'h08);
      stream(0, 4);
      cfg(8'h00);
      drain(12);
      check("flushed", 8'(rx_seen), 8'h00);
      stream(0, 3);
      drain(8);
      check("resumed", 8'(rx_seen), 8'h03);
      check("resumed bit", {7'h0, rx_bit_o[c]}, {7'h0, last[c]});
    end
    give_verdict();
  end
endmodule
